//--- testbench/cpu_model.sv
// CPU side model: AXI4-Lite master tasks and a HALT strobe.
// Assumes tasks are called right after a rising edge of aclk.
`timescale 1ns/1ns
module cpu_model
  import wdg_pkg::*;
(
  input  wire logic              aclk,
  output logic [ADDR_W-1:0]      awaddr,
  output logic                   awvalid,
  input  wire logic              awready,
  output logic [31:0]            wdata,
  output logic [3:0]             wstrb,
  output logic                   wvalid,
  input  wire logic              wready,
  input  wire logic [1:0]        bresp,
  input  wire logic              bvalid,
  output logic                   bready,
  output logic [ADDR_W-1:0]      araddr,
  output logic                   arvalid,
  input  wire logic              arready,
  input  wire logic [31:0]       rdata,
  input  wire logic [1:0]        rresp,
  input  wire logic              rvalid,
  output logic                   rready,
  output logic                   halt_exec
);
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, halt_exec} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
  end
  // Released address and data are inverted so stale values are never seen
  task automatic axi_write(input logic [ADDR_W-1:0] a,
    input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic done;
    done = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge aclk);
  endtask
  task automatic axi_read(input logic [ADDR_W-1:0] a,
    output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge aclk);
  endtask
  task automatic strobe_halt();
    halt_exec <= 1'b1;
    @(posedge aclk);
    halt_exec <= 1'b0;
  endtask
endmodule

//--- testbench/tb.sv
// Self-checking bench for the countdown watchdog core.
// Assumes the CPU model drives the register port and HALT.
`timescale 1ns/1ns
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  errors++; $display("unexpected %s exp %h got %h", n, e, s); end end
module tb
  import wdg_pkg::*;
;
  localparam int PER = 512;
  logic              aclk;
  logic              aresetn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, v;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, timebase_select, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
  logic arready, rvalid, rready, halt_exec, chip_reset_n;
  int                errors, total_checks, w, plen;

  wdg_core #(.PRESC_PERIOD(PER), .STEP_UNIT(1)) dut (.aclk, .aresetn,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .timebase_select, .halt_exec,
    .chip_reset_n);
  cpu_model cpu (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .halt_exec);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic reset_dut();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    cpu.axi_write(a, {24'h0, d}, 4'hF, r);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    cpu.axi_read(a, v, r);
  endtask
  // Cycles until the reset pulse falls, then its length
  task automatic wait_rst(input int lim);
    w = 0;
    plen = 0;
    while (chip_reset_n !== 1'b0 && w < lim) begin
      @(posedge aclk);
      w++;
    end
    while (chip_reset_n === 1'b0) begin
      @(posedge aclk);
      plen++;
    end
  endtask
  task automatic t_regs();
    reset_dut();
    rd(CTRL_OFF);
    `CHK("ctrl", 32'h7F, v)
    rd(OPT_OFF);
    `CHK("opt", 32'h0, v)
    rd(12'h008);
    `CHK("rresp", RESP_SLVERR, r)
    `CHK("rdata", 32'h0, v)
    wr(12'h008, 8'hFF);
    `CHK("bresp", RESP_SLVERR, r)
    $display("test regs done");
  endtask
  task automatic t_free_run();
    reset_dut();
    repeat (PER - 100) @(posedge aclk);
    rd(CTRL_OFF);
    `CHK("cnt0", 8'h7F, v[7:0])
    repeat (200) @(posedge aclk);
    rd(CTRL_OFF);
    `CHK("cnt1", 8'h7E, v[7:0])
    repeat (PER) @(posedge aclk);
    rd(CTRL_OFF);
    `CHK("cnt2", 8'h7D, v[7:0])
    $display("test free_run done");
  endtask
  // Shortest timebase: every tick after the first uses the short period
  task automatic t_tbase();
    timebase_select <= 2'h0;
    reset_dut();
    repeat (600) @(posedge aclk);
    rd(CTRL_OFF);
    `CHK("tb0_a", 8'h7E, v[7:0])
    repeat (200) @(posedge aclk);
    rd(CTRL_OFF);
    `CHK("tb0_b", 8'h7D, v[7:0])
    timebase_select <= 2'h3;
    $display("test tbase done");
  endtask
  task automatic t_timeout();
    reset_dut();
    wr(CTRL_OFF, 8'hC1);
    wait_rst(PER + 50);
    `CHK("early", 0, plen)
    wait_rst(PER);
    `CHK("pulse", PULSE_CYC, plen)
    rd(CTRL_OFF);
    `CHK("act", 1'b1, v[7])
    reset_dut();
    rd(CTRL_OFF);
    `CHK("ctrl", 32'h7F, v)
    $display("test timeout done");
  endtask
  task automatic t_load();
    reset_dut();
    wr(CTRL_OFF, 8'hC5);
    rd(CTRL_OFF);
    `CHK("load", 8'hC5, v[7:0])
    cpu.axi_write(CTRL_OFF, 32'hFF, 4'h0, r);
    rd(CTRL_OFF);
    `CHK("strb", 8'hC5, v[7:0])
    $display("test load done");
  endtask
  task automatic t_soft();
    reset_dut();
    wr(CTRL_OFF, 8'h3F);
    wait_rst(20);
    `CHK("idle", 0, plen)
    wr(CTRL_OFF, 8'h80);
    wait_rst(20);
    `CHK("soft", PULSE_CYC, plen)
    $display("test soft done");
  endtask
  task automatic t_halt();
    reset_dut();
    wr(OPT_OFF, 8'h01);
    cpu.strobe_halt();
    wait_rst(20);
    `CHK("h_off", 0, plen)
    wr(CTRL_OFF, 8'hFF);
    wr(OPT_OFF, 8'h00);
    cpu.strobe_halt();
    wait_rst(20);
    `CHK("h_opt0", 0, plen)
    wr(OPT_OFF, 8'h01);
    cpu.strobe_halt();
    wait_rst(20);
    `CHK("h_on", PULSE_CYC, plen)
    $display("test halt done");
  endtask
  task automatic t_hw();
    reset_dut();
    wr(OPT_OFF, 8'h02);
    wr(CTRL_OFF, 8'h3F);
    wait_rst(20);
    `CHK("hw", PULSE_CYC, plen)
    $display("test hw done");
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge aclk);
    errors++;
    end_of_test();
  end
  initial begin
    aresetn = 1'b0;
    timebase_select = 2'h3;
    errors = 0;
    total_checks = 0;
    t_regs();
    t_free_run();
    t_tbase();
    t_timeout();
    t_load();
    t_soft();
    t_halt();
    t_hw();
    end_of_test();
  end
endmodule

//--- verilog/wdg_core.sv
// Countdown watchdog with an AXI4-Lite register port and reset pulse out.
// Assumes halt_exec and timebase_select come from logic on aclk.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
// Overview of operation
// - Counter decrements once per prescaler period of 16384 clocks.
// - Active watchdog rolling 40h to 3Fh drives reset low about 500ns.
// - Counter runs freely even while the watchdog is not activated.
// - Reset disables the watchdog; once activated it stays on until reset.
// - A write setting activate and clearing the top bit resets at once.
// - While active with the HALT option bit set, a HALT instruction produces a reset.
// - An option bit selects whether HALT produces a reset.
// - An option bit selects the always-on hardware watchdog variant.
// - The six low counter bits give 64 timeout steps.
// - Writes never restart the prescaler, so timeouts vary.
// - Timebase select sets the short prescaler periods from four constant pairs.
// - Minimum timeout uses 16384 per count plus short periods.
// - Maximum timeout uses the same short period substitution.
// - All divisions in the timeout timing truncate downward.
// - Control register resets to 7Fh, activate clear.
// - Hardware variant is always active and ignores the activate bit.
module wdg_core
  import wdg_pkg::*;
#(
  parameter int PRESC_PERIOD = PRESC_DEF,
  parameter int STEP_UNIT    = STEP_DEF
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [1:0]        timebase_select,
  input  wire logic              halt_exec,
  output logic                   chip_reset_n
);
  typedef struct packed {
    wr_cmd_t          wc;
    logic             aw_got;
    logic             w_got;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             act;
    logic [CNT_W-1:0] cnt;
    logic             opt_halt;
    logic             opt_hw;
    logic             rst_go;
  } core_t;

  core_t st;
  core_t nx;
  logic  tick;
  logic  active;
  logic  wr_fire;
  logic  ctl_wr;
  logic  roll;
  logic  sw_rst;
  logic  halt_rst;

  // Timebase-driven decrement ticks; writes leave the phase alone
  wdg_prescaler #(
    .PERIOD (PRESC_PERIOD),
    .UNIT   (STEP_UNIT)
  ) u_pre (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .timebase_select (timebase_select),
    .tick            (tick)
  );

  // Reset pin pulse generator
  wdg_reset_pulse #(
    .LEN (PULSE_CYC)
  ) u_pls (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .start        (st.rst_go),
    .chip_reset_n (chip_reset_n)
  );

  // Hardware variant keeps the watchdog on regardless of activate
  assign active = st.act || st.opt_hw;

  always_comb begin
    nx       = st;
    wr_fire  = st.aw_got && st.w_got && !st.bvalid;
    ctl_wr   = wr_fire && st.wc.addr == CTRL_OFF;
    roll     = 1'b0;
    sw_rst   = 1'b0;
    halt_rst = 1'b0;

    // Write address and data channels, taken in either order
    if (awvalid && st.awready) begin
      nx.aw_got  = 1'b1;
      nx.wc.addr = awaddr;
    end
    if (wvalid && st.wready) begin
      nx.w_got   = 1'b1;
      nx.wc.data = wdata;
      nx.wc.strb = wstrb;
    end
    if (st.bvalid && bready) begin
      nx.bvalid = 1'b0;
    end

    // Free-running countdown
    if (tick) begin
      nx.cnt = st.cnt - CNT_ONE;
      roll   = active && st.cnt == ROLL_FROM && !ctl_wr;
    end

    // Register write once both halves are held
    if (wr_fire) begin
      nx.aw_got = 1'b0;
      nx.w_got  = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp  = RESP_OKAY;
      if (st.wc.addr == CTRL_OFF) begin
        if (st.wc.strb[0]) begin
          nx.act = st.act || st.wc.data[ACT_BIT];
          nx.cnt = st.wc.data[CNT_W-1:0];
          sw_rst = (nx.act || st.opt_hw)
                   && !st.wc.data[TOP_BIT];
        end
      end else if (st.wc.addr == OPT_OFF) begin
        if (st.wc.strb[0]) begin
          nx.opt_halt = st.wc.data[OPT_HALT_BIT];
          nx.opt_hw   = st.wc.data[OPT_HW_BIT];
        end
      end else begin
        nx.bresp = RESP_SLVERR;
      end
    end

    // HALT while active resets when the option allows it
    halt_rst = halt_exec && active && st.opt_halt;

    nx.rst_go  = roll || sw_rst || halt_rst;
    nx.awready = !nx.aw_got && !nx.bvalid;
    nx.wready  = !nx.w_got && !nx.bvalid;

    // Read channel
    if (st.rvalid && rready) begin
      nx.rvalid = 1'b0;
    end
    if (arvalid && st.arready) begin
      nx.rvalid = 1'b1;
      nx.rresp  = RESP_OKAY;
      nx.rdata  = 32'h0000_0000;
      if (araddr == CTRL_OFF) begin
        nx.rdata[ACT_BIT]     = st.act;
        nx.rdata[CNT_W-1:0]   = st.cnt;
      end else if (araddr == OPT_OFF) begin
        nx.rdata[OPT_HALT_BIT] = st.opt_halt;
        nx.rdata[OPT_HW_BIT]   = st.opt_hw;
      end else begin
        nx.rresp = RESP_SLVERR;
      end
    end
    nx.arready = !nx.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st     <= '0;
      st.cnt <= CTRL_RST[CNT_W-1:0];
    end else begin
      st <= nx;
    end
  end

  assign awready = st.awready;
  assign wready  = st.wready;
  assign bvalid  = st.bvalid;
  assign bresp   = st.bresp;
  assign arready = st.arready;
  assign rvalid  = st.rvalid;
  assign rdata   = st.rdata;
  assign rresp   = st.rresp;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_roll;
    tick && active && st.cnt == ROLL_FROM && !ctl_wr;
  endsequence

  sequence s_swrst;
    ctl_wr && st.wc.strb[0] && st.wc.data[ACT_BIT]
      && !st.wc.data[TOP_BIT];
  endsequence

  sequence s_ctl_load;
    ctl_wr && st.wc.strb[0];
  endsequence

  property p_pulse_follows(s);
    s |=> st.rst_go ##1 !chip_reset_n;
  endproperty

  rollover_rst_a: assert property (p_pulse_follows(s_roll))
    else $error("Rollover did not reset");

  sw_reset_a: assert property (p_pulse_follows(s_swrst))
    else $error("Software reset missed");

  free_run_a: assert property (tick && !ctl_wr
    |=> st.cnt == $past(st.cnt) - CNT_ONE)
    else $error("Counter did not decrement");

  hold_cnt_a: assert property (!tick && !ctl_wr |=> $stable(st.cnt))
    else $error("Counter moved without tick");

  act_sticky_a: assert property (st.act |=> st.act)
    else $error("Activate bit cleared");

  halt_rst_a: assert property (halt_exec && active && st.opt_halt
    |=> st.rst_go) else $error("Halt reset missed");

  halt_opt_a: assert property (halt_exec && !st.opt_halt && !tick
    && !wr_fire |=> !st.rst_go) else $error("Halt reset unselected");

  hw_variant_a: assert property (st.opt_hw && !st.act && tick
    && st.cnt == ROLL_FROM && !ctl_wr |=> st.rst_go)
    else $error("Hardware variant inactive");

  load_cnt_a: assert property (s_ctl_load
    |=> st.cnt == $past(st.wc.data[CNT_W-1:0]))
    else $error("Write did not load counter");

  reset_val_a: assert property ($rose(aresetn)
    |-> st.cnt == CTRL_RST[CNT_W-1:0] && !st.act)
    else $error("Bad control reset value");

  bresp_hold_a: assert property (st.bvalid && !bready |=> st.bvalid)
    else $error("Write response dropped");
endmodule

//--- verilog/wdg_pkg.sv
// Constants, types and lookup functions for the countdown watchdog.
// Assumes one 20 MHz clock domain and a 32-bit AXI4-Lite register port.
package wdg_pkg;
  localparam int CLK_NS     = 50;
  localparam int PULSE_NS   = 500;
  localparam int PULSE_CYC  = (PULSE_NS / CLK_NS < 1) ? 1 : PULSE_NS / CLK_NS;
  localparam int PRESC_DEF  = 16384;
  localparam int STEP_DEF   = 64;
  localparam int SHORT_BASE = 192;
  localparam int ADDR_W     = 12;
  localparam int CNT_W      = 7;
  localparam int ACT_BIT    = 7;
  localparam int TOP_BIT    = 6;
  localparam int OPT_HALT_BIT = 0;
  localparam int OPT_HW_BIT   = 1;
  localparam logic [ADDR_W-1:0] CTRL_OFF = 12'h000;
  localparam logic [ADDR_W-1:0] OPT_OFF  = 12'h004;
  localparam logic [7:0]        CTRL_RST = 8'h7F;
  localparam logic [6:0]        ROLL_FROM = 7'h40;
  localparam logic [6:0]        CNT_ONE   = 7'h01;
  localparam logic [6:0]        QUART     = 7'h04;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
    logic [3:0]        strb;
  } wr_cmd_t;

  // Divisor that spaces the short prescaler periods, per timebase
  function automatic logic [6:0] tb_msb(input logic [1:0] tb);
    case (tb)
      2'h0:    tb_msb = 7'h04;
      2'h1:    tb_msb = 7'h08;
      2'h2:    tb_msb = 7'h14;
      default: tb_msb = 7'h31;
    endcase
  endfunction

  // Offset of the short prescaler period, per timebase
  function automatic logic [6:0] tb_lsb(input logic [1:0] tb);
    case (tb)
      2'h0:    tb_lsb = 7'h3B;
      2'h1:    tb_lsb = 7'h35;
      2'h2:    tb_lsb = 7'h23;
      default: tb_lsb = 7'h36;
    endcase
  endfunction
endpackage

//--- verilog/wdg_prescaler.sv
// Free-running prescaler giving one decrement tick per period.
// Assumes timebase_select is on the same clock; it is never reset by writes.
`timescale 1ns/1ns
module wdg_prescaler
  import wdg_pkg::*;
#(
  parameter int PERIOD = PRESC_DEF,
  parameter int UNIT   = STEP_DEF,
  parameter int CW     = $clog2(PERIOD) + 1
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] timebase_select,
  output logic            tick
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [5:0]    acc;
    logic          tick;
  } pre_t;

  pre_t       st;
  pre_t       nx;
  logic [6:0] sum;
  logic [6:0] msb;

  always_comb begin
    nx = st;
    sum = st.acc + QUART;
    msb = tb_msb(timebase_select);
    nx.tick = 1'b0;
    if (st.cnt == '0) begin
      nx.tick = 1'b1;
      // Floor of 4*count/divisor gives the short periods
      if (sum >= msb) begin
        nx.acc = 6'(sum - msb);
        nx.cnt = CW'((SHORT_BASE + int'(tb_lsb(timebase_select))) * UNIT
                     - 1);
      end else begin
        nx.acc = sum[5:0];
        nx.cnt = CW'(PERIOD - 1);
      end
    end else begin
      nx.cnt = st.cnt - CW'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st     <= '0;
      st.cnt <= CW'(PERIOD - 1);
    end else begin
      st <= nx;
    end
  end

  assign tick = st.tick;

  tick_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st.tick |=> !st.tick) else $error("Ticks too close");
endmodule

//--- verilog/wdg_reset_pulse.sv
// Stretches a one-cycle start into a low reset pulse of fixed length.
// Assumes start is a single-cycle pulse from the watchdog core.
`timescale 1ns/1ns
module wdg_reset_pulse
  import wdg_pkg::*;
#(
  parameter int LEN = PULSE_CYC
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic start,
  output logic      chip_reset_n
);
  typedef struct packed {
    logic       busy;
    logic [7:0] cnt;
    logic       out_n;
  } pls_t;

  pls_t       st;
  pls_t       nx;
  logic [7:0] low_len;

  always_comb begin
    nx = st;
    if (start && !st.busy) begin
      nx.busy  = 1'b1;
      nx.out_n = 1'b0;
      nx.cnt   = 8'(LEN - 1);
    end else if (st.busy) begin
      if (st.cnt == 8'h00) begin
        nx.busy  = 1'b0;
        nx.out_n = 1'b1;
      end else begin
        nx.cnt = st.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st       <= '0;
      st.out_n <= 1'b1;
      low_len  <= 8'h00;
    end else begin
      st      <= nx;
      low_len <= st.out_n ? 8'h00 : low_len + 8'h01;
    end
  end

  assign chip_reset_n = st.out_n;

  pulse_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st.out_n) |-> low_len == 8'(LEN)) else $error("Bad pulse width");
endmodule
